// File: bench/fault_reporter_tb.sv
`timescale 1ns/1ps
module fault_reporter_tb
	import fault_pkg::*;
;
	logic sys_clk, srst, gate_drive, dim_in, gate_run, switch_enable, flag_out, flag_oe, blanking, fault_seen;
	monitor_t mon;
	logic [2:0] severity;
	logic [5:0] status_level;
	int mismatches, checks_done, i;
	logic [7:0] mv [8] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h0C, 8'h02, 8'h01};
	logic [2:0] sv [8] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5};
	logic [5:0] lv [6] = '{LVL_NORMAL, LVL_NORMAL, LVL_SEV2, LVL_SEV3, LVL_SEV4, LVL_SEV5};
	fault_reporter #(.STANDBY_COUNT(50)) dut (.sys_clk(sys_clk), .srst(srst), .mon(mon), .gate_drive(gate_drive),
		.dim_in(dim_in), .switch_enable(switch_enable), .flag_out(flag_out), .flag_oe(flag_oe),
		.severity(severity), .status_level(status_level), .blanking(blanking));
	mcu_model mcu (.sys_clk(sys_clk), .srst(srst), .flag_out(flag_out), .flag_oe(flag_oe), .blanking(blanking),
		.fault_seen(fault_seen));
	// Clock of 50 ns period.
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// The gate toggles unless a test stalls it on purpose.
	always @(posedge sys_clk) begin
		if (gate_run) gate_drive <= ~gate_drive;
	end
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step
	task automatic chk(input logic [5:0] got, input logic [5:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	// Bounded wait for the blanking output to reach a level.
	task automatic wait_blank(input logic v);
		int k;
		for (k = 0; k < 3000 && blanking !== v; k++) step(1);
		if (k == 3000) begin
			mismatches++;
			complete_run();
		end
	endtask : wait_blank
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	initial begin
		srst = 1'b1;
		mon = '0;
		gate_drive = 1'b0;
		gate_run = 1'b1;
		dim_in = 1'b1;
		mismatches = 0;
		checks_done = 0;
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		#1;
		chk(switch_enable, 1'b0);
		chk(status_level, LVL_RST);
		chk(severity, SEV_RST);
		chk(flag_out, 1'b0);
		chk(blanking, 1'b1);
		step(2);
		chk(switch_enable, 1'b1);
		wait_blank(1'b0);
		step(1);
		chk(flag_oe, 1'b0);
		chk(fault_seen, 1'b0);
		$display("test reset done");
		// Each condition alone, shutdown only together with the warning, then all of them together.
		for (i = 0; i < 8; i++) begin
			@(posedge sys_clk) mon <= monitor_t'(mv[i]);
			step(2);
			chk(flag_oe, 1'b1);
			chk(severity, sv[i]);
			chk(status_level, lv[sv[i]]);
			if (i == 4) chk(switch_enable, 1'b1);
			if (i == 5) chk(switch_enable, 1'b0);
		end
		@(posedge sys_clk) mon <= monitor_t'(8'hFF);
		step(2);
		chk(status_level, LVL_SEV5);
		chk(fault_seen, 1'b1);
		$display("test severity done");
		// Shutdown holds while the warning stays, clears below it.
		@(posedge sys_clk) mon <= monitor_t'(8'h0C);
		step(2);
		@(posedge sys_clk) mon <= monitor_t'(8'h08);
		step(2);
		chk(switch_enable, 1'b0);
		@(posedge sys_clk) mon <= '0;
		step(2);
		chk(switch_enable, 1'b1);
		chk(flag_oe, 1'b0);
		$display("test thermal done");
		// A steady gate is reported only after the stall limit.
		@(posedge sys_clk) gate_run <= 1'b0;
		step(STALL_CYC - 100);
		chk(severity, SEV_NONE);
		step(110);
		chk(severity, SEV_REG);
		chk(status_level, LVL_SEV2);
		@(posedge sys_clk) gate_run <= 1'b1;
		$display("test stall done");
		// Low dimming gates the switch, a long low restarts the start-up.
		@(posedge sys_clk) dim_in <= 1'b0;
		step(2);
		chk(switch_enable, 1'b0);
		step(60);
		@(posedge sys_clk) dim_in <= 1'b1;
		wait_blank(1'b1);
		chk(blanking, 1'b1);
		// Start-up reports pass through unmasked: over-current, then regulation.
		@(posedge sys_clk) mon <= monitor_t'(8'h02);
		step(2);
		chk(severity, SEV_OCP);
		@(posedge sys_clk) mon <= monitor_t'(8'h20);
		step(2);
		chk(severity, SEV_REG);
		@(posedge sys_clk) mon <= '0;
		step(2);
		chk(flag_oe, 1'b0);
		wait_blank(1'b0);
		step(2);
		chk(switch_enable, 1'b1);
		$display("test standby done");
		complete_run();
	end
endmodule : fault_reporter_tb

// File: bench/mcu_model.sv
`timescale 1ns/1ps
// Controller side: reads the pulled-up flag wire and ignores it while blanking.
// The adjust input is taken as held at the reference, so no false reports arise.
module mcu_model (
	// Clock and reset.
	input  wire logic sys_clk,
	input  wire logic srst,
	// Diagnostic pins.
	input  wire logic flag_out,
	input  wire logic flag_oe,
	input  wire logic blanking,
	// Flag low seen outside the start-up interval.
	output logic      fault_seen
);
	// A released open-drain flag reads high through the pull-up.
	wire logic flag_n = flag_oe ? flag_out : 1'b1;
	// Start-up reports come from inductor charging, so they are skipped.
	always_ff @(posedge sys_clk) begin
		if (srst)
			fault_seen <= 1'b0;
		else if (!blanking && !flag_n)
			fault_seen <= 1'b1;
	end
endmodule : mcu_model

// File: core/fault_reporter.sv
`timescale 1ns/1ps
module fault_reporter
	import fault_pkg::*;
#(
	parameter int unsigned STANDBY_COUNT = STANDBY_CYC
) (
	// Clock and reset.
	input  wire logic       sys_clk,
	input  wire logic       srst,
	// Monitors and controls.
	input  wire monitor_t   mon,
	input  wire logic       gate_drive,
	input  wire logic       dim_in,
	// Switch enable and diagnostic outputs.
	output logic            switch_enable,
	output logic            flag_out,
	output logic            flag_oe,
	output logic [2:0]      severity,
	output logic [5:0]      status_level,
	output logic            blanking
);

	logic        shut_q,    shut_d;
	logic [11:0] stall_q,   stall_d;
	logic        gate_q,    gate_d;
	logic        stalled_q, stalled_d;
	logic [31:0] dimlow_q,  dimlow_d;
	logic [11:0] blank_q,   blank_d;
	run_state_t  state_q,   state_d;
	logic [2:0]  sev_q,     sev_d;
	logic [5:0]  lvl_q,     lvl_d;
	logic        flag_q,    flag_d;
	logic        sw_q,      sw_d;
	logic        blank_out_q, blank_out_d;
	logic [11:0] blank_run_q, blank_run_d;

	localparam logic [11:0] STALL_LIM = 12'(STALL_CYC);
	localparam logic [11:0] BLANK_LIM = 12'(BLANK_CYC);
	localparam logic [11:0] BLANK_MAX = BLANK_LIM + 12'h002;

	// Thermal hysteresis, stall timer, standby timer and start-up sequencing.
	always_comb begin
		shut_d    = shut_q;
		if (mon.temp_above_shut) begin
			shut_d = 1'b1;
		end else if (!mon.temp_above_warn) begin
			shut_d = 1'b0;
		end
		gate_d    = gate_drive;
		stall_d   = stall_q;
		stalled_d = stalled_q;
		// Only count while switching is expected; a gated switch is not a stall.
		if (!sw_q || gate_drive != gate_q) begin
			stall_d   = 12'h000;
			stalled_d = 1'b0;
		end else if (stall_q >= STALL_LIM) begin
			stalled_d = 1'b1;
		end else begin
			stall_d = stall_q + 12'h001;
		end
		dimlow_d  = dim_in ? 32'h0 : ((dimlow_q < STANDBY_COUNT) ? dimlow_q + 32'h1 : dimlow_q);
		state_d   = state_q;
		blank_d   = blank_q;
		unique case (state_q)
			ST_STARTUP: begin
				// Faults still report; the monitor is expected to ignore them meanwhile.
				if (blank_q >= BLANK_LIM) begin
					state_d = ST_RUN;
				end else begin
					blank_d = blank_q + 12'h001;
				end
			end
			ST_RUN: begin
				if (dimlow_q >= STANDBY_COUNT) begin
					state_d = ST_STANDBY;
				end
			end
			ST_STANDBY: begin
				if (dim_in) begin
					state_d = ST_STARTUP;
					blank_d = 12'h000;
				end
			end
		endcase
		sw_d = dim_in && !shut_d && (state_d != ST_STANDBY);
		blank_out_d = (state_d == ST_STARTUP);
	end

	// Highest severity wins, then the fixed level table.
	always_comb begin
		flag_d = |mon || stalled_q;
		sev_d  = SEV_NONE;
		if (mon.shunt_over || mon.switch_avg_over) begin
			sev_d = SEV_OCP;
		end else if (mon.temp_above_warn) begin
			sev_d = SEV_HOT;
		end else if (mon.switch_node_over) begin
			sev_d = SEV_OVP;
		end else if (mon.main_supply_low || mon.sense_out_of_range || stalled_q) begin
			sev_d = SEV_REG;
		end else if (mon.aux_supply_low) begin
			sev_d = SEV_AUX;
		end
		unique case (sev_d)
			SEV_REG: lvl_d = LVL_SEV2;
			SEV_OVP: lvl_d = LVL_SEV3;
			SEV_HOT: lvl_d = LVL_SEV4;
			SEV_OCP: lvl_d = LVL_SEV5;
			default: lvl_d = LVL_NORMAL;
		endcase
	end

	// State registers.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			shut_q    <= 1'b0;
			stall_q   <= 12'h000;
			gate_q    <= 1'b0;
			stalled_q <= 1'b0;
			dimlow_q  <= 32'h0;
			blank_q   <= 12'h000;
			state_q   <= ST_STARTUP;
			sev_q     <= SEV_RST;
			lvl_q     <= LVL_RST;
			flag_q    <= 1'b0;
			sw_q      <= 1'b0;
			blank_out_q <= 1'b1;
		end else begin
			shut_q    <= shut_d;
			stall_q   <= stall_d;
			gate_q    <= gate_d;
			stalled_q <= stalled_d;
			dimlow_q  <= dimlow_d;
			blank_q   <= blank_d;
			state_q   <= state_d;
			sev_q     <= sev_d;
			lvl_q     <= lvl_d;
			flag_q    <= flag_d;
			sw_q      <= sw_d;
			blank_out_q <= blank_out_d;
		end
	end

	// Flag pin drives only low; the pad pull-up gives the released level.
	assign flag_out      = 1'b0;
	assign flag_oe       = flag_q;
	assign severity      = sev_q;
	assign status_level  = lvl_q;
	assign switch_enable = sw_q;
	assign blanking      = blank_out_q;

	// Length of the current blanking run, kept only for the checks below.
	// It saturates so that a stuck blanking output cannot wrap and hide itself.
	always_comb begin
		blank_run_d = blank_run_q;
		if (!blanking) begin
			blank_run_d = 12'h000;
		end else if (blank_run_q != 12'hFFF) begin
			blank_run_d = blank_run_q + 12'h001;
		end
	end

	// Helper register for the blanking length checks.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			blank_run_q <= 12'h000;
		end else begin
			blank_run_q <= blank_run_d;
		end
	end

	// Checks.
	AST_SHUT_OFF: assert property (@(posedge sys_clk) disable iff (srst)
		mon.temp_above_shut |=> !switch_enable) else $error("switch on while overheated");
	AST_SHUT_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
		shut_q && mon.temp_above_warn |=> !switch_enable) else $error("restart before cooling");
	AST_FLAG: assert property (@(posedge sys_clk) disable iff (srst)
		(|mon) |=> flag_oe) else $error("flag not pulled low");
	AST_IDLE: assert property (@(posedge sys_clk) disable iff (srst)
		(mon == '0) && !stalled_q |=> !flag_oe && status_level == LVL_NORMAL) else $error("not idle");
	AST_AUX: assert property (@(posedge sys_clk) disable iff (srst)
		(mon == 8'h80) && !stalled_q |=> severity == SEV_AUX && status_level == LVL_NORMAL)
		else $error("aux level wrong");
	AST_OCP: assert property (@(posedge sys_clk) disable iff (srst)
		mon.shunt_over |=> severity == SEV_OCP && status_level == LVL_SEV5) else $error("ocp lost");
	AST_HOT: assert property (@(posedge sys_clk) disable iff (srst)
		mon.temp_above_warn && !mon.shunt_over && !mon.switch_avg_over |=> severity == SEV_HOT)
		else $error("hot lost");
	AST_OVP: assert property (@(posedge sys_clk) disable iff (srst)
		mon.switch_node_over |=> severity >= SEV_OVP) else $error("ovp outranked");
	// A held gate while the switch may run is what the stall timer counts.
	sequence s_steady_on;
		switch_enable && (gate_drive == gate_q);
	endsequence
	AST_STALL: assert property (@(posedge sys_clk) disable iff (srst)
		stalled_q |-> flag_oe || $past(!stalled_q)) else $error("stall not flagged");
	AST_STARTUP: assert property (@(posedge sys_clk) disable iff (srst)
		state_q == ST_STANDBY && dim_in |=> blanking) else $error("no start-up");
	AST_DIM: assert property (@(posedge sys_clk) disable iff (srst)
		!dim_in |=> !switch_enable) else $error("switch on while dimmed");

	// The checks below follow the timers step by step.
	// A broken counter would let a stall or a short blanking slip through,
	// so each end point of each counter is watched on its own.

	// A held gate below the limit advances the stall timer by one.
	AST_STALL_CNT: assert property (@(posedge sys_clk) disable iff (srst)
		s_steady_on ##0 (stall_q < STALL_LIM) |=> stall_q == $past(stall_q) + 12'h001)
		else $error("stall timer did not advance");

	// A gate edge or a gated switch restarts the stall timer.
	AST_STALL_CLR: assert property (@(posedge sys_clk) disable iff (srst)
		!switch_enable || (gate_drive != gate_q) |=> stall_q == 12'h000 && !stalled_q)
		else $error("stall timer not cleared");

	// Reaching the limit with the gate still held marks the driver stalled.
	AST_STALL_SET: assert property (@(posedge sys_clk) disable iff (srst)
		s_steady_on ##0 (stall_q >= STALL_LIM) |=> stalled_q) else $error("stall not detected");

	// Leaving standby with the dimming input high starts a fresh blanking run.
	sequence s_blank_start;
		state_q == ST_STANDBY && dim_in;
	endsequence

	// The blanking run lasts far longer than eight cycles once started.
	AST_BLANK_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
		s_blank_start |=> blanking [*8]) else $error("blanking cut short");

	// The start-up interval ends once its counter reaches the limit.
	AST_BLANK_EXIT: assert property (@(posedge sys_clk) disable iff (srst)
		state_q == ST_STARTUP && blank_q >= BLANK_LIM |=> !blanking) else $error("blanking never ends");

	// Blanking must not outlast the start-up interval.
	AST_BLANK_MAX: assert property (@(posedge sys_clk) disable iff (srst)
		blanking |-> blank_run_q <= BLANK_MAX) else $error("blanking too long");

	// Blanking must not end before the start-up interval is over.
	AST_BLANK_MIN: assert property (@(posedge sys_clk) disable iff (srst)
		$fell(blanking) |-> blank_run_q >= BLANK_LIM) else $error("blanking too short");

	// A long low dimming input enters standby: switch off, no blanking yet.
	AST_STANDBY: assert property (@(posedge sys_clk) disable iff (srst)
		state_q == ST_RUN && dimlow_q >= STANDBY_COUNT |=> !switch_enable && !blanking)
		else $error("standby not entered");

	// A cool device with the dimming input high switches again.
	AST_RESUME: assert property (@(posedge sys_clk) disable iff (srst)
		state_q == ST_RUN && dim_in && dimlow_q < STANDBY_COUNT && !mon.temp_above_warn
		&& !mon.temp_above_shut |=> switch_enable) else $error("switch not resumed");

	// A warning alone does not stop switching.
	AST_WARN_RUN: assert property (@(posedge sys_clk) disable iff (srst)
		state_q == ST_RUN && dim_in && dimlow_q < STANDBY_COUNT && mon.temp_above_warn
		&& !mon.temp_above_shut && !shut_q |=> switch_enable) else $error("warning stopped switch");

	// A low auxiliary supply still pulls the flag.
	AST_AUX_FLAG: assert property (@(posedge sys_clk) disable iff (srst)
		mon.aux_supply_low |=> flag_oe) else $error("aux not flagged");

	// Low main supply with nothing more severe reports severity 2.
	AST_REG: assert property (@(posedge sys_clk) disable iff (srst)
		mon.main_supply_low && !mon.shunt_over && !mon.switch_avg_over && !mon.temp_above_warn
		&& !mon.switch_node_over |=> severity == SEV_REG) else $error("supply low lost");

	// Any reported severity comes with the flag pulled low.
	AST_FLAG_SEV: assert property (@(posedge sys_clk) disable iff (srst)
		severity != SEV_NONE |-> flag_oe) else $error("severity without flag");

	// The level table, one entry at a time.
	AST_LVL_REG: assert property (@(posedge sys_clk) disable iff (srst)
		severity == SEV_REG |-> status_level == LVL_SEV2) else $error("level 2 wrong");

	AST_LVL_OVP: assert property (@(posedge sys_clk) disable iff (srst)
		severity == SEV_OVP |-> status_level == LVL_SEV3) else $error("level 3 wrong");

	AST_LVL_HOT: assert property (@(posedge sys_clk) disable iff (srst)
		severity == SEV_HOT |-> status_level == LVL_SEV4) else $error("level 4 wrong");

	AST_LVL_OCP: assert property (@(posedge sys_clk) disable iff (srst)
		severity == SEV_OCP |-> status_level == LVL_SEV5) else $error("level 5 wrong");

	// Normal operation and severity 1 share the top level.
	AST_LVL_LOW: assert property (@(posedge sys_clk) disable iff (srst)
		severity <= SEV_AUX |-> status_level == LVL_NORMAL) else $error("top level wrong");

endmodule : fault_reporter

// File: pkg/fault_pkg.sv
package fault_pkg;

	// Clock rate and derived cycle counts.
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned STALL_US        = 100;
	localparam int unsigned BLANK_US        = 100;
	localparam int unsigned STANDBY_MS      = 15;
	localparam int unsigned STALL_CYC       = (STALL_US * (CLK_HZ / 1_000_000));
	localparam int unsigned BLANK_CYC       = (BLANK_US * (CLK_HZ / 1_000_000));
	localparam int unsigned STANDBY_CYC     = (STANDBY_MS * (CLK_HZ / 1_000));

	// Severity codes, zero meaning normal operation.
	localparam logic [2:0]  SEV_NONE        = 3'h0;
	localparam logic [2:0]  SEV_AUX         = 3'h1;
	localparam logic [2:0]  SEV_REG         = 3'h2;
	localparam logic [2:0]  SEV_OVP         = 3'h3;
	localparam logic [2:0]  SEV_HOT         = 3'h4;
	localparam logic [2:0]  SEV_OCP         = 3'h5;

	// Status levels in tenths of a volt.
	localparam logic [5:0]  LVL_NORMAL      = 6'h2D;
	localparam logic [5:0]  LVL_SEV2        = 6'h24;
	localparam logic [5:0]  LVL_SEV3        = 6'h1B;
	localparam logic [5:0]  LVL_SEV4        = 6'h12;
	localparam logic [5:0]  LVL_SEV5        = 6'h09;

	// Reset values.
	localparam logic [2:0]  SEV_RST         = 3'h0;
	localparam logic [5:0]  LVL_RST         = 6'h2D;

	// Comparator results from the analogue monitors.
	typedef struct packed {
		logic aux_supply_low;
		logic main_supply_low;
		logic sense_out_of_range;
		logic switch_node_over;
		logic temp_above_warn;
		logic temp_above_shut;
		logic shunt_over;
		logic switch_avg_over;
	} monitor_t;

	typedef enum logic [1:0] {
		ST_STARTUP = 2'b00,
		ST_RUN     = 2'b01,
		ST_STANDBY = 2'b11
	} run_state_t;

endpackage : fault_pkg
